// ===== verilog/flash_cfg_defs.svh
// constants for the volatile read configuration block
// assumes inclusion by bare name from the design files
`ifndef FLASH_CFG_DEFS_SVH
`define FLASH_CFG_DEFS_SVH

// ****************************************
// volatile register fields
// ****************************************
`define VCFG_DUMMY 7:4
`define VCFG_XIP_BIT 3
`define VCFG_RSVD_BIT 2
`define VCFG_WRAP 1:0
`define VCFG_RESET 8'hfb

// ****************************************
// nonvolatile register fields
// ****************************************
`define NV_DUMMY 15:12
`define NV_XIP 11:9
`define NV_XIP_OFF 3'h7
`define NV_QUAD_BIT 3
`define NV_DUAL_BIT 2
`define NV_FACTORY 16'hffff

// ****************************************
// dummy and wrap encodings
// ****************************************
`define DUMMY_CODE_DEF0 4'h0
`define DUMMY_CODE_DEF1 4'hf
`define DUMMY_DEFAULT 4'ha
`define WRAP_16 2'h0
`define WRAP_32 2'h1
`define WRAP_64 2'h2
`define WRAP_SEQ 2'h3
`define MASK_16 32'h0000000f
`define MASK_32 32'h0000001f
`define MASK_64 32'h0000003f
`define MASK_SEQ 32'hffffffff

`endif

// ===== verilog/flash_cfg_pkg.sv
// types for the volatile read configuration block
// assumes nothing beyond a SystemVerilog compiler
package flash_cfg_pkg;

  typedef enum logic [1:0] {phase_idle, phase_dummy, phase_data} read_phase_t;

endpackage : flash_cfg_pkg

// ===== verilog/flash_wrap_addr.sv
// next byte address of a read under the selected wrap mode
// assumes a combinational use inside the read engine
`timescale 1ns/1ps
`default_nettype none
`include "flash_cfg_defs.svh"

module flash_wrap_addr (
  input wire logic [31:0] cur_addr,
  input wire logic [1:0] wrap_sel,
  output logic [31:0] wrap_mask,
  output logic [31:0] next_addr
);

  // ****************************************
  // aligned block mask
  // ****************************************
  wire [31:0] inc_addr;

  assign wrap_mask = (wrap_sel == `WRAP_16) ? `MASK_16 :
                     (wrap_sel == `WRAP_32) ? `MASK_32 :
                     (wrap_sel == `WRAP_64) ? `MASK_64 : `MASK_SEQ;
  assign inc_addr = cur_addr + 32'h00000001;
  // low bits advance, block base held
  assign next_addr = (cur_addr & ~wrap_mask) | (inc_addr & wrap_mask);

endmodule : flash_wrap_addr
`default_nettype wire

// ===== verilog/flash_read_config_wrap.sv
// volatile read configuration register and the read sequencing it steers
// assumes command decode and serial clock ticks arrive on core_clk
// Functional notes
// - fast reads insert the dummy clock count held in bits 7:4
// - dummy codes 0000 and 1111 both mean the default count
// - nonvolatile bits 2/3 low pick dual/quad at power-on, quad wins
// - volatile bit 3 low enables execute in place; fixed variants ignore it
// - wrap codes 00/01/10 wrap within aligned 16/32/64-byte blocks
// - wrap code 11 is the default and reads sequentially
// - writes to the volatile register act at once and read back
// - nonvolatile bits 15:12 give power-on dummy count, factory all ones
`timescale 1ns/1ps
`default_nettype none
`include "flash_cfg_defs.svh"

module flash_read_config_wrap
  import flash_cfg_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [15:0] nv_config,
  input wire logic xip_fixed,
  input wire logic vcfg_wr,
  input wire logic [7:0] vcfg_wdata,
  input wire logic read_start,
  input wire logic read_fast,
  input wire logic [31:0] read_addr,
  input wire logic sclk_tick,
  input wire logic byte_next,
  input wire logic read_end,
  output logic [7:0] vcfg_rdata,
  output logic [3:0] dummy_cycles,
  output logic proto_dual,
  output logic proto_quad,
  output logic execute_in_place,
  output logic dummy_phase,
  output logic data_phase,
  output logic [31:0] byte_addr
);

  // ****************************************
  // state
  // ****************************************
  logic loaded;
  logic [7:0] vcfg;
  logic fixed_xip;
  read_phase_t phase;
  logic [3:0] dummy_left;

  wire load_now;
  wire wr_ok;
  wire [3:0] dummy_code;
  wire [3:0] eff_dummy;
  wire [7:0] wr_value;
  wire [7:0] nv_value;
  wire next_xip;
  wire [31:0] wrap_mask;
  wire [31:0] next_byte_addr;
  wire dummy_done;
  read_phase_t next_phase;

  // ****************************************
  // decode
  // ****************************************
  assign load_now = !loaded;
  assign wr_ok = loaded && vcfg_wr;
  assign dummy_code = vcfg[`VCFG_DUMMY];
  assign eff_dummy = (dummy_code == `DUMMY_CODE_DEF0 || dummy_code == `DUMMY_CODE_DEF1) ?
                     `DUMMY_DEFAULT : dummy_code;
  assign wr_value = {vcfg_wdata[`VCFG_DUMMY], vcfg_wdata[`VCFG_XIP_BIT], 1'b0,
                     vcfg_wdata[`VCFG_WRAP]};
  // power-on image: dummy from nonvolatile field, xip from its mode field
  assign nv_value = {nv_config[`NV_DUMMY], (nv_config[`NV_XIP] == `NV_XIP_OFF), 1'b0,
                     `WRAP_SEQ};
  assign next_xip = fixed_xip || !vcfg[`VCFG_XIP_BIT];
  assign dummy_done = (phase == phase_dummy) && sclk_tick && (dummy_left == 4'h1);

  always_comb begin
    next_phase = phase;
    if (read_end) begin
      next_phase = phase_idle;
    end else if (read_start) begin
      next_phase = read_fast ? phase_dummy : phase_data;
    end else if (dummy_done) begin
      next_phase = phase_data;
    end
  end

  flash_wrap_addr u_wrap (
    .cur_addr(byte_addr),
    .wrap_sel(vcfg[`VCFG_WRAP]),
    .wrap_mask(wrap_mask),
    .next_addr(next_byte_addr)
  );

  // ****************************************
  // configuration register
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      loaded <= 1'b0;
      vcfg <= `VCFG_RESET;
      fixed_xip <= 1'b0;
      proto_dual <= 1'b0;
      proto_quad <= 1'b0;
    end else if (load_now) begin
      loaded <= 1'b1;
      vcfg <= nv_value;
      fixed_xip <= xip_fixed;
      proto_quad <= !nv_config[`NV_QUAD_BIT];
      proto_dual <= nv_config[`NV_QUAD_BIT] && !nv_config[`NV_DUAL_BIT];
    end else if (wr_ok) begin
      vcfg <= wr_value;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      vcfg_rdata <= `VCFG_RESET;
      dummy_cycles <= `DUMMY_DEFAULT;
      execute_in_place <= 1'b0;
    end else begin
      vcfg_rdata <= vcfg;
      dummy_cycles <= eff_dummy;
      execute_in_place <= next_xip;
    end
  end

  // ****************************************
  // read sequencing
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      phase <= phase_idle;
      dummy_phase <= 1'b0;
      data_phase <= 1'b0;
    end else begin
      phase <= next_phase;
      dummy_phase <= (next_phase == phase_dummy);
      data_phase <= (next_phase == phase_data);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      dummy_left <= 4'h0;
    end else if (read_start && !read_end) begin
      dummy_left <= eff_dummy;
    end else if (phase == phase_dummy && sclk_tick) begin
      dummy_left <= dummy_left - 4'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      byte_addr <= 32'h00000000;
    end else if (read_start && !read_end) begin
      byte_addr <= read_addr;
    end else if (phase == phase_data && byte_next && !read_end) begin
      byte_addr <= next_byte_addr;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  sequence seq_fast_start;
    read_start && read_fast && !read_end;
  endsequence

  sequence seq_byte_step;
    phase == phase_data && byte_next && !read_end && !read_start;
  endsequence

  sequence seq_dummy_last;
    dummy_done && !read_start && !read_end;
  endsequence

  sequence seq_dummy_wait;
    phase == phase_dummy && !dummy_done && !read_start && !read_end;
  endsequence

  chk_dummy_load: assert property (seq_fast_start |=> dummy_left == $past(eff_dummy))
    else $error("dummy count not loaded at fast read start");

  chk_dummy_enter: assert property (seq_fast_start |=> dummy_phase && !data_phase)
    else $error("fast read did not enter the dummy phase");

  chk_dummy_hold: assert property (seq_dummy_wait |=> dummy_phase && !data_phase)
    else $error("dummy phase left before its count ran out");

  chk_dummy_exit: assert property (seq_dummy_last |=> data_phase && !dummy_phase)
    else $error("dummy phase did not hand over to data");

  chk_dummy_default: assert property ((dummy_code == 4'h0 || dummy_code == 4'hf) |=>
      dummy_cycles == 4'ha)
    else $error("default dummy code not mapped to default count");

  chk_dummy_literal: assert property ((dummy_code != 4'h0 && dummy_code != 4'hf) |->
      eff_dummy == dummy_code ##1 dummy_cycles == $past(dummy_code))
    else $error("literal dummy code altered");

  chk_proto_sel: assert property (loaded && !$past(loaded) |->
      proto_quad == !$past(nv_config[3]) && !(proto_quad && proto_dual))
    else $error("protocol select wrong at power-on");

  chk_xip_fixed: assert property (loaded && fixed_xip |=> execute_in_place)
    else $error("fixed variant not in execute in place");

  chk_wrap_block: assert property (seq_byte_step ##0 (vcfg[1:0] != 2'h3) |=>
      (byte_addr & ~$past(wrap_mask)) == ($past(byte_addr) & ~$past(wrap_mask)))
    else $error("wrapped read left its aligned block");

  chk_seq_incr: assert property (seq_byte_step ##0 (vcfg[1:0] == 2'h3) |=>
      byte_addr == $past(byte_addr) + 32'h00000001)
    else $error("sequential read did not increment");

  chk_wr_effect: assert property (wr_ok |=> vcfg == {$past(vcfg_wdata[7:3]), 1'b0,
      $past(vcfg_wdata[1:0])} ##1 vcfg_rdata == $past(vcfg))
    else $error("volatile write not applied or not readable");

  chk_nv_load: assert property (load_now |=> vcfg[7:4] == $past(nv_config[15:12]) &&
      vcfg[1:0] == 2'h3)
    else $error("power-on dummy count not taken from nonvolatile field");

endmodule : flash_read_config_wrap
`default_nettype wire

// ===== verification/flash_host_model.sv
// host controller model that issues reads to the read engine
// assumes the bench calls its tasks from one process
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
  input wire logic core_clk,
  output logic read_start,
  output logic read_fast,
  output logic [31:0] read_addr,
  output logic sclk_tick,
  output logic byte_next,
  output logic read_end
);
  initial begin
    {read_start, read_fast, sclk_tick, byte_next, read_end} = 5'h00;
    read_addr = 32'h0;
  end
  // ****************************************
  // read command
  // ****************************************
  task automatic start(input logic fast, input logic [31:0] addr);
    @(posedge core_clk);
    read_start <= 1'b1;
    read_fast <= fast;
    read_addr <= addr;
    @(posedge core_clk);
    read_start <= 1'b0;
  endtask : start
  // ****************************************
  // tick, byte or end strobe; spacing keeps serial clock near 10 mhz
  // ****************************************
  task automatic pulse(input int sel);
    @(posedge core_clk);
    case (sel)
      0: sclk_tick <= 1'b1;
      1: byte_next <= 1'b1;
      default: read_end <= 1'b1;
    endcase
    @(posedge core_clk);
    {sclk_tick, byte_next, read_end} <= 3'h0;
    repeat (2) @(posedge core_clk);
  endtask : pulse
endmodule : flash_host_model
`default_nettype wire

// ===== verification/flash_read_config_wrap_tb.sv
// self-checking bench for the volatile read configuration block
// assumes the design files and the host model are compiled first
`timescale 1ns/1ps
`default_nettype none
module flash_read_config_wrap_tb;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] nv_config = 16'h3ff3;
  logic xip_fixed = 1'b0;
  logic vcfg_wr = 1'b0;
  logic [7:0] vcfg_wdata = 8'h00;
  wire logic read_start, read_fast, sclk_tick, byte_next, read_end;
  wire logic [31:0] read_addr, byte_addr;
  wire logic [7:0] vcfg_rdata;
  wire logic [3:0] dummy_cycles;
  wire logic proto_dual, proto_quad, execute_in_place, dummy_phase, data_phase;
  int mismatches = 0;
  int check_count = 0;
  always #12.5 core_clk = ~core_clk;
  flash_host_model host (.core_clk(core_clk), .read_start(read_start),
    .read_fast(read_fast), .read_addr(read_addr), .sclk_tick(sclk_tick),
    .byte_next(byte_next), .read_end(read_end));
  flash_read_config_wrap DUT (.core_clk(core_clk), .resetn(resetn),
    .nv_config(nv_config), .xip_fixed(xip_fixed), .vcfg_wr(vcfg_wr),
    .vcfg_wdata(vcfg_wdata), .read_start(read_start), .read_fast(read_fast),
    .read_addr(read_addr), .sclk_tick(sclk_tick), .byte_next(byte_next),
    .read_end(read_end), .vcfg_rdata(vcfg_rdata), .dummy_cycles(dummy_cycles),
    .proto_dual(proto_dual), .proto_quad(proto_quad),
    .execute_in_place(execute_in_place), .dummy_phase(dummy_phase),
    .data_phase(data_phase), .byte_addr(byte_addr));
  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : settle
  task automatic do_reset(input logic fixed);
    @(posedge core_clk);
    resetn <= 1'b0;
    xip_fixed <= fixed;
    settle(12);
    check("rst_rdata", 32'hfb, vcfg_rdata);
    check("rst_dummy", 32'ha, dummy_cycles);
    @(posedge core_clk);
    resetn <= 1'b1;
    settle(3);
  endtask : do_reset
  task automatic write_cfg(input logic [7:0] d);
    @(posedge core_clk);
    vcfg_wr <= 1'b1;
    vcfg_wdata <= d;
    @(posedge core_clk);
    vcfg_wr <= 1'b0;
    settle(2);
  endtask : write_cfg
  task automatic read_wrap(input logic [1:0] w, input logic [31:0] a, input logic fast,
                           input int n);
    int i;
    logic [31:0] m;
    m = (w == 2'h3) ? 32'hffffffff : (32'h10 << w) - 32'h1;
    host.start(fast, a);
    settle(1);
    check("start_addr", a, byte_addr);
    check("dummy_phase", fast, dummy_phase);
    check("data_phase", !fast, data_phase);
    for (i = 0; i < n; i++) begin
      check("early_data", 32'h0, data_phase);
      host.pulse(0);
    end
    for (i = 0; i < 40 && data_phase !== 1'b1; i++) settle(1);
    if (i == 40) begin
      mismatches++;
      tally_and_finish();
    end
    repeat (3) begin
      host.pulse(1);
      a = (a & ~m) | ((a + 32'h1) & m);
      check("byte_addr", a, byte_addr);
    end
    host.pulse(2);
    check("phases", 32'h0, {dummy_phase, data_phase});
  endtask : read_wrap
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    static logic [7:0] wv[4] = '{8'h0f, 8'hd7, 8'hfb, 8'h24};
    do_reset(1'b0);
    check("pon_rdata", 32'h3b, vcfg_rdata);
    check("pon_dummy", 32'h3, dummy_cycles);
    check("quad", 32'h1, proto_quad);
    check("dual", 32'h0, proto_dual);
    foreach (wv[k]) begin
      write_cfg(wv[k]);
      check("rdata", wv[k] & 8'hfb, vcfg_rdata);
      check("dummy", (wv[k][7:4] inside {4'h0, 4'hf}) ? 4'ha : wv[k][7:4], dummy_cycles);
      check("xip", !wv[k][3], execute_in_place);
    end
    for (int w = 0; w < 4; w++) begin
      write_cfg({4'(w + 1), 2'b10, 2'(w)});
      read_wrap(2'(w), (32'h20 << w) - 32'h2, 1'b1, w + 1);
    end
    read_wrap(2'h3, 32'hff, 1'b0, 0);
    nv_config <= 16'hfffb;
    do_reset(1'b1);
    check("xip_fixed", 32'h1, execute_in_place);
    check("dual_pon", 32'h1, proto_dual);
    check("quad_pon", 32'h0, proto_quad);
    check("def_dummy", 32'ha, dummy_cycles);
    check("def_rdata", 32'hfb, vcfg_rdata);
    write_cfg(8'h18);
    check("xip_held", 32'h1, execute_in_place);
    tally_and_finish();
  end
endmodule : flash_read_config_wrap_tb
`default_nettype wire
